/* File: pkg/rlio_pkg.sv */
// rlio_pkg: shared constants, types and helpers for the relay logic i/o block
package rlio_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and sizes
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned LATCH_COUNT   = 8;
  localparam int unsigned COND_COUNT    = 8;
  localparam int unsigned OC_COUNT      = 4;
  localparam int unsigned SEL_W         = 3;
  localparam int unsigned PIN_COUNT     = 24;
  localparam int unsigned CNT_W         = 27;

  //////////////////////////////////////////////////////////////////////////////
  // times in their own units, and the derived cycle counts
  localparam int unsigned SCAN_PERIOD_US   = 1000;
  localparam int unsigned SCAN_CYC         = (CLK_HZ / 1_000_000) * SCAN_PERIOD_US;
  localparam int unsigned CLEAR_WINDOW_S   = 5;
  localparam int unsigned CLEAR_WINDOW_CYC = CLK_HZ * CLEAR_WINDOW_S;
  localparam int unsigned CLOSE_FAIL_MS    = 500;
  localparam int unsigned CLOSE_FAIL_CYC   = (CLK_HZ / 1000) * CLOSE_FAIL_MS;

  //////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [LATCH_COUNT-1:0] LATCH_RST = 8'h00;
  localparam logic [COND_COUNT-1:0]  FLAG_RST  = 8'h00;
  localparam logic [PIN_COUNT-1:0]   PIN_RST   = 24'h00_0000;
  localparam logic                   ALARM_RST = 1'b1;
  localparam logic [CNT_W-1:0]       CNT_RST   = 27'h000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {TAG_ON, TAG_HOLD, TAG_HOT, TAG_TAG} rlio_tag_t;
  typedef enum logic [1:0] {BKR_UNKNOWN, BKR_OPEN, BKR_CLOSED} rlio_bkr_t;

  // rising edge between two successive scans
  function automatic logic rlio_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : rlio_rise

endpackage : rlio_pkg

/* File: tb/rlio_breaker_model.sv */
// rlio_breaker_model: breaker mechanism with its two auxiliary contacts
`timescale 1ns/100ps
`default_nettype none
module rlio_breaker_model (
  input  wire logic sys_clk,
  input  wire logic trip,
  input  wire logic close,
  input  wire logic slow,
  input  wire logic fault,
  output logic      aux_a,
  output logic      aux_b
);
  logic       want;
  logic [1:0] cnt;
  initial begin
    want = 1'b0;
    cnt = 2'h0;
    aux_a = 1'b0;
    aux_b = 1'b1;
  end
  // slow models a stuck mechanism that never closes; fault welds both contacts
  always @(posedge sys_clk) begin
    if (trip) begin
      want <= 1'b0;
    end else if (close && !slow) begin
      want <= 1'b1;
    end
    if (fault) begin
      {aux_a, aux_b} <= 2'h3;
    end else if (cnt == 2'h3) begin
      {aux_a, aux_b} <= {want, ~want};
    end
    cnt <= (want == aux_a && !fault) ? 2'h0 : cnt + 2'h1;
  end
endmodule : rlio_breaker_model
`default_nettype wire

/* File: tb/rlio_checker.sv */
// rlio_checker: port-level assertions for the relay logic i/o block
`timescale 1ns/100ps
`default_nettype none
module rlio_checker
  import rlio_pkg::*;
#(
  parameter int unsigned CLOSE_FAIL = 16
)
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       sync_element_ok,
  input wire logic       sync_check_enable_out,
  input wire logic       sync_check_permissive_out,
  input wire logic [7:0] alarm_cond,
  input wire logic [7:0] rt_flag_out,
  input wire logic [7:0] seal_flag_out,
  input wire logic       seal_in_clear_in,
  input wire logic       front_operator_panel_confirm,
  input wire logic       clear_prompt_out,
  input wire logic       remote_trip_req,
  input wire logic       remote_close_req,
  input wire logic       remote_seal_clr_all,
  input wire logic       remote_seal_clr_one,
  input wire logic       remote_cmd_rejected,
  input wire logic [7:0] latch_out,
  input wire rlio_tag_t  hot_hold_tag_state,
  input wire logic       alarm_out,
  input wire logic       trip_out,
  input wire logic       close_out,
  input wire logic       breaker_aux_a,
  input wire logic       breaker_aux_b,
  input wire rlio_bkr_t  breaker_state
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////
  // clear pin reaches the flags late; allow a margin
  logic        [7:0] clr_age;
  int unsigned       close_len;
  always_ff @(posedge sys_clk) begin
    clr_age <= (!rst_n || seal_in_clear_in) ? 8'h00 : (clr_age == 8'hFF ? 8'hFF : clr_age + 8'h01);
  end
  always_ff @(posedge sys_clk) begin
    close_len <= (!rst_n || !close_out) ? 0 : close_len + 1;
  end

  ////////////////////////
  reset_vals_a: assert property (
    $rose(rst_n) |-> alarm_out && latch_out == 8'h00 && seal_flag_out == 8'h00 && !trip_out && !close_out
      && hot_hold_tag_state == TAG_ON) else $error("outputs not at reset values");
  perm_follow_a: assert property (
    sync_check_enable_out && $past(sync_element_ok) |-> sync_check_permissive_out)
    else $error("permissive low while enabled element ok");
  rt_flag_a: assert property (
    $past(rst_n) |-> rt_flag_out == $past(alarm_cond)) else $error("real-time flag not tracking condition");
  seal_set_a: assert property (
    $past(rst_n) |-> (rt_flag_out & ~seal_flag_out) == 8'h00) else $error("sealed flag missing");
  seal_drop_a: assert property (
    |($past(seal_flag_out) & ~seal_flag_out) && clr_age > 8'h0C |-> $past(remote_seal_clr_all)
      || $past(remote_seal_clr_one) || ($past(front_operator_panel_confirm) && $past(clear_prompt_out)))
    else $error("sealed flag dropped without clear");
  reject_cause_a: assert property (
    remote_cmd_rejected |-> $past(remote_trip_req) || $past(remote_close_req) || $past(remote_seal_clr_all)
      || $past(remote_seal_clr_one)) else $error("reject pulse without remote request");
  trip_close_a: assert property (
    trip_out |=> !close_out) else $error("close held during trip");
  close_len_a: assert property (
    close_len <= CLOSE_FAIL + 1) else $error("close outlived close-fail time");
  bkr_closed_a: assert property (
    (breaker_aux_a && !breaker_aux_b) [*5] |-> breaker_state == BKR_CLOSED) else $error("closed not decoded");
  bkr_open_a: assert property (
    (!breaker_aux_a && breaker_aux_b) [*5] |-> breaker_state == BKR_OPEN) else $error("open not decoded");
  tag_step_a: assert property (
    hot_hold_tag_state != $past(hot_hold_tag_state) |-> {1'b0, hot_hold_tag_state} + 3'h1
      == {1'b0, $past(hot_hold_tag_state)} || {1'b0, $past(hot_hold_tag_state)} + 3'h1
      == {1'b0, hot_hold_tag_state}) else $error("tag moved more than one step");

  close_c: cover property ($rose(close_out));
  tag_end_c: cover property (hot_hold_tag_state == TAG_TAG);
  reject_c: cover property (remote_cmd_rejected);
  prompt_c: cover property ($fell(clear_prompt_out));
endmodule : rlio_checker
`default_nettype wire

/* File: tb/test_rlio_top.sv */
// test_rlio_top: self-checking bench for the relay logic i/o block
`timescale 1ns/100ps
`default_nettype none
module test_rlio_top;
  import rlio_pkg::*;
  localparam int unsigned SD = 4;
  localparam int unsigned CW = 20;
  localparam int unsigned CF = 16;
  typedef struct packed {
    logic [7:0] s, r;
    logic [1:0] stp;
    logic [2:0] ctl;
    logic [7:0] el;
    rlio_tag_t  et;
  } rlio_row_t;
  // stp: bit0 step up, bit1 step down; ctl: enable, bypass, open
  rlio_row_t rows [16] = '{
    '{8'h01, 8'h00, 2'h1, 3'h4, 8'h01, TAG_HOLD}, '{8'h00, 8'h00, 2'h0, 3'h0, 8'h01, TAG_HOLD},
    '{8'hF0, 8'h00, 2'h1, 3'h2, 8'hF1, TAG_HOT},  '{8'h00, 8'h00, 2'h0, 3'h6, 8'hF1, TAG_HOT},
    '{8'h00, 8'h01, 2'h1, 3'h1, 8'hF0, TAG_TAG},  '{8'h00, 8'h00, 2'h0, 3'h0, 8'hF0, TAG_TAG},
    '{8'h00, 8'h00, 2'h1, 3'h0, 8'hF0, TAG_TAG},  '{8'h00, 8'h04, 2'h2, 3'h0, 8'hF0, TAG_HOT},
    '{8'h04, 8'h04, 2'h3, 3'h0, 8'hF0, TAG_HOT},  '{8'h04, 8'h00, 2'h1, 3'h0, 8'hF0, TAG_HOT},
    '{8'h08, 8'h00, 2'h0, 3'h0, 8'hF8, TAG_HOT},  '{8'h08, 8'h08, 2'h2, 3'h0, 8'hF8, TAG_HOLD},
    '{8'h00, 8'h08, 2'h0, 3'h0, 8'hF8, TAG_HOLD}, '{8'h00, 8'h00, 2'h2, 3'h0, 8'hF8, TAG_ON},
    '{8'h00, 8'h00, 2'h0, 3'h0, 8'hF8, TAG_ON},   '{8'h00, 8'hF8, 2'h2, 3'h0, 8'h00, TAG_ON}};

  logic sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0, fault = 1'b0;
  logic sync_check_en_in = 1'b0, sync_check_bypass_in = 1'b0, local_ctrl_in = 1'b0, seal_in_clear_in = 1'b0;
  logic [7:0] latch_set_in = 8'h00, latch_reset_in = 8'h00, alarm_cond = 8'h00;
  logic tag_step_up_in = 1'b0, tag_step_down_in = 1'b0, open_cmd_in = 1'b0, close_cmd_in = 1'b0;
  logic self_check_ok = 1'b1, sync_element_ok = 1'b1, breaker_aux_a, breaker_aux_b;
  logic [3:0] oc_operate = 4'h0;
  logic front_operator_panel_trip = 1'b0, front_operator_panel_close = 1'b0;
  logic front_operator_panel_clear_btn = 1'b0, front_operator_panel_confirm = 1'b0;
  logic remote_trip_req = 1'b0, remote_close_req = 1'b0, remote_seal_clr_all = 1'b0, remote_seal_clr_one = 1'b0;
  logic [2:0] remote_seal_sel = 3'h0;
  logic sync_check_enable_out, sync_check_permissive_out, alarm_out, clear_prompt_out, remote_cmd_rejected;
  logic [7:0] latch_out, rt_flag_out, seal_flag_out;
  logic trip_out, close_out;
  rlio_tag_t hot_hold_tag_state;
  rlio_bkr_t breaker_state;
  int mismatches = 0, total_checks = 0;

  rlio_top #(.SCAN_DIV(SD), .CLEAR_WIN(CW), .CLOSE_FAIL(CF)) rlio_top_i (.sys_clk, .rst_n,
    .sync_check_en_in, .sync_check_bypass_in, .local_ctrl_in, .seal_in_clear_in, .latch_set_in,
    .latch_reset_in, .tag_step_up_in, .tag_step_down_in, .open_cmd_in, .close_cmd_in, .breaker_aux_a,
    .breaker_aux_b, .self_check_ok, .sync_element_ok, .oc_operate, .alarm_cond, .front_operator_panel_trip,
    .front_operator_panel_close, .front_operator_panel_clear_btn, .front_operator_panel_confirm,
    .remote_trip_req, .remote_close_req, .remote_seal_clr_all, .remote_seal_clr_one, .remote_seal_sel,
    .sync_check_enable_out, .sync_check_permissive_out, .latch_out, .hot_hold_tag_state, .alarm_out,
    .rt_flag_out, .seal_flag_out, .clear_prompt_out, .remote_cmd_rejected, .trip_out, .close_out, .breaker_state);
  rlio_breaker_model rlio_breaker_model_i (.sys_clk, .trip(trip_out), .close(close_out), .slow, .fault,
    .aux_a(breaker_aux_a), .aux_b(breaker_aux_b));

  always #20 sys_clk = ~sys_clk;

  ////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    #160000;
    mismatches++;
    conclude;
  end

  ////////////////////////
  initial begin
    tick(3);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      {latch_set_in, latch_reset_in} = {rows[i].s, rows[i].r};
      {tag_step_down_in, tag_step_up_in} = rows[i].stp;
      {sync_check_en_in, sync_check_bypass_in, open_cmd_in} = rows[i].ctl;
      tick(9);
      chk(latch_out, rows[i].el);
      chk(hot_hold_tag_state, rows[i].et);
      chk(sync_check_enable_out, rows[i].ctl[2]);
      chk(sync_check_permissive_out, rows[i].ctl[2] | rows[i].ctl[1]);
      chk(trip_out, rows[i].ctl[0]);
    end
    $display("test table done");
    sync_element_ok = 1'b0;
    sync_check_en_in = 1'b1;
    tick(9);
    chk(sync_check_enable_out, 1'b1);
    chk(sync_check_permissive_out, 1'b0);
    sync_check_en_in = 1'b0;
    sync_element_ok = 1'b1;
    $display("test sync done");
    alarm_cond = 8'h24;
    tick(1);
    alarm_cond = 8'h00;
    chk(rt_flag_out, 8'h24);
    tick(1);
    chk(rt_flag_out, 8'h00);
    chk(seal_flag_out, 8'h24);
    remote_seal_clr_one = 1'b1;
    remote_seal_sel = 3'h2;
    tick(1);
    remote_seal_clr_one = 1'b0;
    chk(seal_flag_out, 8'h20);
    local_ctrl_in = 1'b1;
    tick(9);
    remote_seal_clr_all = 1'b1;
    tick(1);
    remote_seal_clr_all = 1'b0;
    chk(remote_cmd_rejected, 1'b1);
    chk(seal_flag_out, 8'h20);
    local_ctrl_in = 1'b0;
    tick(9);
    remote_seal_clr_all = 1'b1;
    tick(1);
    remote_seal_clr_all = 1'b0;
    chk(seal_flag_out, 8'h00);
    $display("test remote flags done");
    alarm_cond = 8'h81;
    tick(1);
    alarm_cond = 8'h00;
    front_operator_panel_confirm = 1'b1;
    tick(1);
    front_operator_panel_confirm = 1'b0;
    chk(seal_flag_out, 8'h81);
    front_operator_panel_clear_btn = 1'b1;
    tick(1);
    front_operator_panel_clear_btn = 1'b0;
    chk(clear_prompt_out, 1'b1);
    front_operator_panel_confirm = 1'b1;
    tick(1);
    front_operator_panel_confirm = 1'b0;
    chk(seal_flag_out, 8'h00);
    chk(clear_prompt_out, 1'b0);
    front_operator_panel_clear_btn = 1'b1;
    tick(1);
    front_operator_panel_clear_btn = 1'b0;
    tick(CW + 3);
    chk(clear_prompt_out, 1'b0);
    alarm_cond = 8'h02;
    tick(1);
    alarm_cond = 8'h00;
    seal_in_clear_in = 1'b1;
    tick(9);
    seal_in_clear_in = 1'b0;
    chk(seal_flag_out, 8'h00);
    $display("test panel clear done");
    chk(breaker_state, BKR_OPEN);
    oc_operate = 4'h2;
    tick(1);
    oc_operate = 4'h0;
    chk(trip_out, 1'b1);
    tick(2);
    front_operator_panel_close = 1'b1;
    tick(1);
    front_operator_panel_close = 1'b0;
    chk(close_out, 1'b1);
    tick(14);
    chk(close_out, 1'b0);
    chk(breaker_state, BKR_CLOSED);
    front_operator_panel_trip = 1'b1;
    tick(1);
    front_operator_panel_trip = 1'b0;
    chk(trip_out, 1'b1);
    tick(14);
    chk(trip_out, 1'b0);
    chk(breaker_state, BKR_OPEN);
    slow = 1'b1;
    remote_close_req = 1'b1;
    tick(1);
    remote_close_req = 1'b0;
    tick(8);
    chk(close_out, 1'b1);
    tick(12);
    chk(close_out, 1'b0);
    slow = 1'b0;
    remote_trip_req = 1'b1;
    tick(1);
    remote_trip_req = 1'b0;
    chk(trip_out, 1'b1);
    tick(3);
    close_cmd_in = 1'b1;
    for (int i = 0; i < 14 && close_out !== 1'b1; i++) tick(1);
    chk(close_out, 1'b1);
    close_cmd_in = 1'b0;
    tick(14);
    chk(breaker_state, BKR_CLOSED);
    fault = 1'b1;
    tick(6);
    chk(breaker_state, BKR_UNKNOWN);
    fault = 1'b0;
    $display("test breaker done");
    latch_set_in = 8'h11;
    tick(9);
    latch_set_in = 8'h00;
    self_check_ok = 1'b0;
    tick(1);
    chk(alarm_out, 1'b0);
    self_check_ok = 1'b1;
    rst_n = 1'b0;
    tick(3);
    chk(alarm_out, 1'b1);
    chk(latch_out, 8'h00);
    chk(close_out, 1'b0);
    chk(breaker_state, BKR_UNKNOWN);
    rst_n = 1'b1;
    tick(2);
    $display("test reset done");
    conclude;
  end
endmodule : test_rlio_top

bind rlio_top rlio_checker #(.CLOSE_FAIL(CLOSE_FAIL)) rlio_checker_i (.sys_clk, .rst_n, .sync_element_ok,
  .sync_check_enable_out, .sync_check_permissive_out, .alarm_cond, .rt_flag_out, .seal_flag_out,
  .seal_in_clear_in, .front_operator_panel_confirm, .clear_prompt_out, .remote_trip_req, .remote_close_req,
  .remote_seal_clr_all, .remote_seal_clr_one, .remote_cmd_rejected, .latch_out, .hot_hold_tag_state,
  .alarm_out, .trip_out, .close_out, .breaker_aux_a, .breaker_aux_b, .breaker_state);
`default_nettype wire

/* File: verilog/rlio_latch_bank.sv */
// rlio_latch_bank: eight set/reset latching logical outputs
`timescale 1ns/100ps
`default_nettype none
module rlio_latch_bank
  import rlio_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // scanned levels
  input  wire logic                   scan_upd,
  input  wire logic [LATCH_COUNT-1:0] set_cur,
  input  wire logic [LATCH_COUNT-1:0] set_prev,
  input  wire logic [LATCH_COUNT-1:0] rst_cur,
  input  wire logic [LATCH_COUNT-1:0] rst_prev,
  // latch state
  output logic      [LATCH_COUNT-1:0] latch_out
);

  logic [LATCH_COUNT-1:0] latch_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // an edge that starts while the opposite input is held is dropped for good,
  // since only a fresh edge can act later
  always_comb begin
    latch_nxt = latch_out;
    for (int i = 0; i < LATCH_COUNT; i++) begin
      if (rlio_rise(set_cur[i], set_prev[i]) && !rst_cur[i]) begin
        latch_nxt[i] = 1'b1;
      end else if (rlio_rise(rst_cur[i], rst_prev[i]) && !set_cur[i]) begin
        latch_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latch_out <= LATCH_RST;
    end else if (scan_upd) begin
      latch_out <= latch_nxt;
    end
  end

endmodule : rlio_latch_bank
`default_nettype wire

/* File: verilog/rlio_tag_stepper.sv */
// rlio_tag_stepper: four-position hot hold tag state stepped up and down
`timescale 1ns/100ps
`default_nettype none
module rlio_tag_stepper
  import rlio_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // scanned levels
  input  wire logic scan_upd,
  input  wire logic up_cur,
  input  wire logic up_prev,
  input  wire logic down_cur,
  input  wire logic down_prev,
  // tag state
  output var  rlio_tag_t hot_hold_tag_state
);

  rlio_tag_t tag_nxt;
  logic      up_ev;
  logic      down_ev;

  //////////////////////////////////////////////////////////////////////////////
  // one position per accepted edge; a held input never steps twice
  always_comb begin
    up_ev   = rlio_rise(up_cur, up_prev) && !down_cur && (hot_hold_tag_state != TAG_TAG);
    down_ev = rlio_rise(down_cur, down_prev) && !up_cur && (hot_hold_tag_state != TAG_ON);
    tag_nxt = hot_hold_tag_state;
    case (hot_hold_tag_state)
      TAG_ON: begin
        if (up_ev) tag_nxt = TAG_HOLD;
      end
      TAG_HOLD: begin
        if (up_ev) tag_nxt = TAG_HOT;
        else if (down_ev) tag_nxt = TAG_ON;
      end
      TAG_HOT: begin
        if (up_ev) tag_nxt = TAG_TAG;
        else if (down_ev) tag_nxt = TAG_HOLD;
      end
      TAG_TAG: begin
        if (down_ev) tag_nxt = TAG_HOT;
      end
      default: begin
        tag_nxt = TAG_ON;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hot_hold_tag_state <= TAG_ON;
    end else if (scan_upd) begin
      hot_hold_tag_state <= tag_nxt;
    end
  end

endmodule : rlio_tag_stepper
`default_nettype wire

/* File: verilog/rlio_top.sv */
// rlio_top: logical inputs, latches, tag, seal-in flags and breaker outputs
`timescale 1ns/100ps
`default_nettype none
module rlio_top
  import rlio_pkg::*;
#(
  parameter int unsigned SCAN_DIV      = SCAN_CYC,
  parameter int unsigned CLEAR_WIN     = CLEAR_WINDOW_CYC,
  parameter int unsigned CLOSE_FAIL    = CLOSE_FAIL_CYC
)
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // contact inputs from pins
  input  wire logic                   sync_check_en_in,
  input  wire logic                   sync_check_bypass_in,
  input  wire logic                   local_ctrl_in,
  input  wire logic                   seal_in_clear_in,
  input  wire logic [LATCH_COUNT-1:0] latch_set_in,
  input  wire logic [LATCH_COUNT-1:0] latch_reset_in,
  input  wire logic                   tag_step_up_in,
  input  wire logic                   tag_step_down_in,
  input  wire logic                   open_cmd_in,
  input  wire logic                   close_cmd_in,
  input  wire logic                   breaker_aux_a,
  input  wire logic                   breaker_aux_b,
  // internal element status
  input  wire logic                   self_check_ok,
  input  wire logic                   sync_element_ok,
  input  wire logic [OC_COUNT-1:0]    oc_operate,
  input  wire logic [COND_COUNT-1:0]  alarm_cond,
  // front operator panel requests
  input  wire logic                   front_operator_panel_trip,
  input  wire logic                   front_operator_panel_close,
  input  wire logic                   front_operator_panel_clear_btn,
  input  wire logic                   front_operator_panel_confirm,
  // remote requests
  input  wire logic                   remote_trip_req,
  input  wire logic                   remote_close_req,
  input  wire logic                   remote_seal_clr_all,
  input  wire logic                   remote_seal_clr_one,
  input  wire logic [SEL_W-1:0]       remote_seal_sel,
  // sync check
  output logic                        sync_check_enable_out,
  output logic                        sync_check_permissive_out,
  // latches and tag
  output logic      [LATCH_COUNT-1:0] latch_out,
  output var  rlio_tag_t              hot_hold_tag_state,
  // flags
  output logic                        alarm_out,
  output logic      [COND_COUNT-1:0]  rt_flag_out,
  output logic      [COND_COUNT-1:0]  seal_flag_out,
  output logic                        clear_prompt_out,
  output logic                        remote_cmd_rejected,
  // breaker
  output logic                        trip_out,
  output logic                        close_out,
  output var  rlio_bkr_t              breaker_state
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and scan sampling

  localparam int unsigned P_SYNC_EN = 23;
  localparam int unsigned P_BYPASS  = 22;
  localparam int unsigned P_LOCAL   = 21;
  localparam int unsigned P_SIA     = 20;
  localparam int unsigned P_SET_LO  = 12;
  localparam int unsigned P_RST_LO  = 4;
  localparam int unsigned P_UP      = 3;
  localparam int unsigned P_DOWN    = 2;
  localparam int unsigned P_OPEN    = 1;
  localparam int unsigned P_CLOSE   = 0;

  logic [PIN_COUNT-1:0] pin_meta_r;
  logic [PIN_COUNT-1:0] pin_sync_r;
  logic [PIN_COUNT-1:0] scan_r;
  logic [PIN_COUNT-1:0] prev_r;
  logic [1:0]           aux_meta_r;
  logic [1:0]           aux_sync_r;
  logic [CNT_W-1:0]     scan_cnt_r;
  logic                 scan_tick;
  logic                 scan_upd_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_r <= PIN_RST;
      pin_sync_r <= PIN_RST;
      aux_meta_r <= 2'h0;
      aux_sync_r <= 2'h0;
    end else begin
      pin_meta_r <= {sync_check_en_in, sync_check_bypass_in, local_ctrl_in, seal_in_clear_in,
                     latch_set_in, latch_reset_in, tag_step_up_in, tag_step_down_in,
                     open_cmd_in, close_cmd_in};
      pin_sync_r <= pin_meta_r;
      aux_meta_r <= {breaker_aux_a, breaker_aux_b};
      aux_sync_r <= aux_meta_r;
    end
  end

  // scan divider: one enable pulse per scan period
  assign scan_tick = (scan_cnt_r == CNT_W'(SCAN_DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scan_cnt_r <= CNT_RST;
    end else if (scan_tick) begin
      scan_cnt_r <= CNT_RST;
    end else begin
      scan_cnt_r <= scan_cnt_r + CNT_W'(1);
    end
  end

  // the previous scan is kept so requests act once per rising edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scan_r     <= PIN_RST;
      prev_r     <= PIN_RST;
      scan_upd_r <= 1'b0;
    end else begin
      scan_upd_r <= scan_tick;
      if (scan_tick) begin
        prev_r <= scan_r;
        scan_r <= pin_sync_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync check

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_check_enable_out     <= 1'b0;
      sync_check_permissive_out <= 1'b0;
    end else begin
      sync_check_enable_out     <= scan_r[P_SYNC_EN];
      sync_check_permissive_out <= scan_r[P_BYPASS] | (scan_r[P_SYNC_EN] & sync_element_ok);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latches and hot hold tag

  rlio_latch_bank u_latch (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .scan_upd (scan_upd_r),
    .set_cur  (scan_r[P_SET_LO +: LATCH_COUNT]),
    .set_prev (prev_r[P_SET_LO +: LATCH_COUNT]),
    .rst_cur  (scan_r[P_RST_LO +: LATCH_COUNT]),
    .rst_prev (prev_r[P_RST_LO +: LATCH_COUNT]),
    .latch_out(latch_out)
  );

  rlio_tag_stepper u_tag (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .scan_upd          (scan_upd_r),
    .up_cur            (scan_r[P_UP]),
    .up_prev           (prev_r[P_UP]),
    .down_cur          (scan_r[P_DOWN]),
    .down_prev         (prev_r[P_DOWN]),
    .hot_hold_tag_state(hot_hold_tag_state)
  );

  //////////////////////////////////////////////////////////////////////////////
  // remote command gating

  logic remote_any;
  logic remote_ok;

  assign remote_any = remote_trip_req | remote_close_req | remote_seal_clr_all | remote_seal_clr_one;
  assign remote_ok  = !scan_r[P_LOCAL];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      remote_cmd_rejected <= 1'b0;
    end else begin
      remote_cmd_rejected <= remote_any & ~remote_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // panel clear window

  logic             clear_win_r;
  logic [CNT_W-1:0] clear_cnt_r;
  logic             panel_clear;

  // a second press restarts the window rather than clearing
  assign panel_clear = clear_win_r & front_operator_panel_confirm;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clear_win_r <= 1'b0;
      clear_cnt_r <= CNT_RST;
    end else if (front_operator_panel_clear_btn) begin
      clear_win_r <= 1'b1;
      clear_cnt_r <= CNT_RST;
    end else if (panel_clear || (clear_cnt_r == CNT_W'(CLEAR_WIN - 1))) begin
      clear_win_r <= 1'b0;
      clear_cnt_r <= CNT_RST;
    end else if (clear_win_r) begin
      clear_cnt_r <= clear_cnt_r + CNT_W'(1);
    end
  end

  assign clear_prompt_out = clear_win_r;

  //////////////////////////////////////////////////////////////////////////////
  // real-time and sealed-in flags

  logic [COND_COUNT-1:0] seal_clr;
  logic [COND_COUNT-1:0] sel_mask;

  always_comb begin
    sel_mask = '0;
    sel_mask[remote_seal_sel] = 1'b1;
    seal_clr = '0;
    if (panel_clear || scan_r[P_SIA] || (remote_ok && remote_seal_clr_all)) begin
      seal_clr = '1;
    end else if (remote_ok && remote_seal_clr_one) begin
      seal_clr = sel_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rt_flag_out   <= FLAG_RST;
      seal_flag_out <= FLAG_RST;
      alarm_out     <= ALARM_RST;
    end else begin
      rt_flag_out   <= alarm_cond;
      // a condition present in the clear cycle keeps its flag set
      seal_flag_out <= (seal_flag_out & ~seal_clr) | alarm_cond;
      alarm_out     <= self_check_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // breaker position, trip and close

  rlio_bkr_t        bkr_nxt;
  logic             man_trip_r;
  logic             man_trip_set;
  logic             close_set;
  logic             close_done;
  logic [CNT_W-1:0] close_cnt_r;

  always_comb begin
    case (aux_sync_r)
      2'b10: bkr_nxt = BKR_CLOSED;
      2'b01: bkr_nxt = BKR_OPEN;
      default: bkr_nxt = BKR_UNKNOWN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      breaker_state <= BKR_UNKNOWN;
    end else begin
      breaker_state <= bkr_nxt;
    end
  end

  assign man_trip_set = front_operator_panel_trip | (remote_ok & remote_trip_req);
  assign close_set    = (scan_upd_r & rlio_rise(scan_r[P_CLOSE], prev_r[P_CLOSE]))
                      | front_operator_panel_close | (remote_ok & remote_close_req);
  assign close_done   = (close_cnt_r == CNT_W'(CLOSE_FAIL - 1)) || (breaker_state == BKR_CLOSED);

  // manual trip holds until the breaker reports open; a new request wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      man_trip_r <= 1'b0;
    end else if (man_trip_set) begin
      man_trip_r <= 1'b1;
    end else if (breaker_state == BKR_OPEN) begin
      man_trip_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trip_out <= 1'b0;
    end else begin
      trip_out <= (|oc_operate) | scan_r[P_OPEN] | man_trip_r | man_trip_set;
    end
  end

  // trip cancels a pending close a cycle later, so trip_out and close_out overlap for at most one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      close_out   <= 1'b0;
      close_cnt_r <= CNT_RST;
    end else if (trip_out) begin
      close_out   <= 1'b0;
      close_cnt_r <= CNT_RST;
    end else if (close_set) begin
      close_out   <= 1'b1;
      close_cnt_r <= CNT_RST;
    end else if (close_out && close_done) begin
      close_out   <= 1'b0;
      close_cnt_r <= CNT_RST;
    end else if (close_out) begin
      close_cnt_r <= close_cnt_r + CNT_W'(1);
    end
  end

endmodule : rlio_top
`default_nettype wire
